// ---- verilog/pdl_host.sv ----
// What this block does
// RL1 - Device clears status bits except service request when status is read.
// RL2 - Service request clears only after the data byte moves on the bus.
// RL3 - Interrupt status bit 0 shows a link controller interrupt.
// RL4 - Interrupt status bit 1 shows the 4 ms timer interrupt.
// RL5 - Interrupt status bit 2 shows the channel jumper selection.
// RL6 - Station address resets to 01, primary; host skips it as primary (code writes 01 to the station port anyway).
// RL7 - As secondary, host writes terminal number 1-31 into upper five bits.
// RL8 - As secondary the device swaps its transmit and receive pairs.
// RL9 - CPU transmit: host writes command with bit 3 and frame/flag bits.
// RL10 - Host supplies each byte promptly after each interrupt, else error.
// RL11 - Host ends CPU frame with terminate pattern 0xxx1000 promptly.
// RL12 - Host writes group address before unique, group or global receive.
// RL13 - Combined receive and transmit commands perform transmit first.
// RL14 - Receive interrupts per byte; host reads each byte promptly.
// RL15 - Host reads status after each byte: EOF done, other bit error.
// RL16 - Host discards the final byte that set end of frame.
// RL17 - Host sets the DMA byte counter to FF before a DMA transfer.
// RL18 - DMA address registers take only the low eight address bits.
// RL19 - Command 11xx0000 fills with flags; 10xx0000 idles after frame.
// RL20 - DMA transmit ends with interrupt; DMA-terminated marks success.
// RL21 - DMA group address written with four upper bits, low bits set.
// RL22 - DMA receive ends with EOF status, plus DMA-terminated if exhausted.
// RL23 - Receive mode field: 0 off, 1 all, 2 group/global/unique, 3 unique.
// RL24 - Global station address recognised is F9.
// RL25 - DMA-terminated sets on counter exhaustion or terminal count.
// RL26 - Bit time follows line rate; deadlines run from each interrupt.
// RL27 - Interrupt status register is read-only, bits 3 to 7 zero.
module pdl_host
	import pdl_pkg::*;
(
	input  wire logic         clk_i,          // 50 MHz clock
	input  wire logic         nrst_i,         // Async reset, active low
	input  wire logic         ce_i,           // Clock enable
	input  wire logic         req_valid_i,    // User request valid
	input  pdl_req_s          req_i,          // User request
	output logic              req_ready_o,    // Idle, request accepted
	input  wire logic [7:0]   tx_data_i,      // Transmit byte
	input  wire logic         tx_valid_i,     // Transmit byte valid
	input  wire logic         tx_last_i,      // Transmit byte is last
	output logic              tx_ready_o,     // Transmit byte taken
	output logic [7:0]        rx_data_o,      // Received byte
	output logic              rx_valid_o,     // Received byte valid
	input  wire logic         rx_ready_i,     // Received byte taken
	output logic              done_o,         // Operation done pulse
	output pdl_res_s          res_o,          // Result of operation
	output logic [9:0]        io_addr_o,      // Adapter I/O address
	output logic [7:0]        io_wdata_o,     // Data bus out
	output logic              io_data_oe_o,   // Data bus drive enable
	input  wire logic [7:0]   io_rdata_i,     // Data bus in
	output logic              io_rd_n_o,      // I/O read strobe, low
	output logic              io_wr_n_o,      // I/O write strobe, low
	input  wire logic         irq_i           // Adapter interrupt pin
);
	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [3:0] {
		S_IDLE   = 4'b0000,
		S_SETUP  = 4'b0001,
		S_CMD    = 4'b0010,
		S_WAIT   = 4'b0011,
		S_STAT   = 4'b0100,
		S_DATA   = 4'b0101,
		S_TERM   = 4'b0110,
		S_ISTAT  = 4'b0111,
		S_DONE   = 4'b1000
	} pdl_state_e;

	pdl_state_e  st_q, st_d;
	pdl_req_s    rq_q, rq_d;
	pdl_io_s     io_q, io_d;
	logic [2:0]  step_q, step_d;
	logic [3:0]  tmr_q, tmr_d;
	logic        last_q, last_d;
	logic        done_q, done_d;
	pdl_res_s    res_q, res_d;
	logic [7:0]  hold_q, hold_d;
	logic        have_q, have_d;
	logic        rd_n_q, wr_n_q;
	logic [7:0]  cmd;
	logic        irq_s;
	logic        f_in_rdy, f_out_vld;
	logic [7:0]  f_out;
	logic        f_pop, f_push, f_clr;
	logic        busy;
	logic        is_tx, is_rx, is_dma;

	// Interrupt pin synchroniser
	pdl_sync #(.W(1)) u_sync (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.en_i    (ce_i),
		.async_i (irq_i),
		.sync_o  (irq_s)
	);

	// Receive byte buffer toward the user
	pdl_fifo #(.W(FIFO_W), .D(FIFO_D)) u_rxbuf (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.en_i        (ce_i),
		.clr_i       (f_clr),
		.in_data_i   (hold_q),
		.in_valid_i  (f_push),
		.in_ready_o  (f_in_rdy),
		.out_data_o  (f_out),
		.out_valid_o (f_out_vld),
		.out_ready_i (f_pop)
	);

	// ****************************************
	// Command byte assembly
	// ****************************************
	always_comb begin
		is_tx  = (rq_q.op == PDL_OP_TXCPU) || (rq_q.op == PDL_OP_TXDMA);
		is_rx  = (rq_q.op == PDL_OP_RXCPU) || (rq_q.op == PDL_OP_RXDMA);
		is_dma = (rq_q.op == PDL_OP_TXDMA) || (rq_q.op == PDL_OP_RXDMA);
		cmd = 8'h00;
		cmd[CMD_TXFRAME] = is_tx;                       // RL9
		cmd[CMD_TXFLAGS] = is_tx && rq_q.flags;          // RL19
		cmd[CMD_RXHI]    = is_rx && rq_q.rx_mode[1];     // RL23
		cmd[CMD_RXLO]    = is_rx && rq_q.rx_mode[0];     // RL23
		cmd[CMD_CPUMODE] = !is_dma;                      // RL9
		busy = io_q.rd || io_q.wr || (tmr_q != '0);
		f_clr = (st_q == S_IDLE) && req_valid_i;
	end

	// ****************************************
	// Main sequencer
	// ****************************************
	always_comb begin
		st_d = st_q;
		rq_d = rq_q;
		io_d = io_q;
		step_d = step_q;
		tmr_d = (tmr_q != '0) ? 4'(tmr_q - 1'b1) : tmr_q;
		last_d = last_q;
		done_d = 1'b0;
		res_d = res_q;
		hold_d = hold_q;
		have_d = have_q;
		f_push = 1'b0;
		f_pop = 1'b0;
		// Strobe ends when the hold time expires
		if ((io_q.rd || io_q.wr) && tmr_q == 4'h1) begin
			io_d.rd = 1'b0;
			io_d.wr = 1'b0;
		end
		// Pass buffered receive data out
		if (f_out_vld && (!rx_valid_o || rx_ready_i)) begin
			f_pop = 1'b1;
		end
		if (have_q && f_in_rdy) begin
			f_push = 1'b1;
			have_d = 1'b0;
		end
		case (st_q)
			S_IDLE: begin
				if (req_valid_i) begin
					rq_d = req_i;
					step_d = '0;
					res_d = '0;
					st_d = S_SETUP;
				end
			end
			S_SETUP: begin
				if (!busy) begin
					tmr_d = 4'(STROBE_CYC);
					io_d.wr = 1'b1;
					step_d = 3'(step_q + 1'b1);
					case (step_q)
						3'd0: begin
							io_d.addr = PORT_STATCMD;
							io_d.data = CMD_RESET;   // RL6
						end
						3'd1: begin
							io_d.addr = PORT_STATION;
							io_d.data = (rq_q.terminal == 5'h00) ? STATION_PRIMARY
								: {rq_q.terminal, STATION_LOW[2:0]}; // RL7
						end
						3'd2: begin
							io_d.addr = PORT_GROUP;
							io_d.data = {rq_q.group, GROUP_LOW[3:0]}; // RL12 RL21
						end
						3'd3: begin
							io_d.addr = (rq_q.op == PDL_OP_RXDMA) ? PORT_RXCOUNT
								: PORT_TXCOUNT;
							io_d.data = DMA_COUNT_INIT;   // RL17
						end
						default: begin
							io_d.addr = (rq_q.op == PDL_OP_RXDMA) ? PORT_RXADDR
								: PORT_TXADDR;
							io_d.data = rq_q.dma_addr;    // RL18
							st_d = S_CMD;
						end
					endcase
					if (step_q == 3'd2 && rq_q.op == PDL_OP_INIT) begin
						st_d = S_DONE;
					end
					if (step_q == 3'd2 && !is_dma && rq_q.op != PDL_OP_INIT) begin
						st_d = S_CMD;
					end
				end
			end
			S_CMD: begin
				if (!busy) begin
					tmr_d = 4'(STROBE_CYC);
					io_d = '{rd: 1'b0, wr: 1'b1, addr: PORT_STATCMD, data: cmd};
					last_d = 1'b0;
					st_d = S_WAIT;
				end
			end
			S_WAIT: begin
				// Each interrupt opens a six bit-time window; react at once
				if (!busy && irq_s) begin                // RL10 RL14
					if (rq_q.op == PDL_OP_TXCPU && !last_q) begin
						st_d = S_DATA;
					end else if (rq_q.op == PDL_OP_TXCPU) begin
						st_d = S_TERM;                      // RL11
					end else if (rq_q.op == PDL_OP_RXCPU) begin
						st_d = S_DATA;
					end else begin
						st_d = S_STAT;                      // RL20 RL22
					end
				end
			end
			S_DATA: begin
				if (!busy) begin
					tmr_d = 4'(STROBE_CYC);
					io_d.addr = PORT_DATA;
					if (rq_q.op == PDL_OP_TXCPU) begin
						if (tx_valid_i) begin
							io_d.wr = 1'b1;
							io_d.data = tx_data_i;
							last_d = tx_last_i;
							st_d = S_STAT;
						end
					end else if (f_in_rdy && !have_q) begin
						io_d.rd = 1'b1;                     // RL14
						st_d = S_STAT;
					end
				end
			end
			S_TERM: begin
				if (!busy) begin
					tmr_d = 4'(STROBE_CYC);
					io_d = '{rd: 1'b0, wr: 1'b1, addr: PORT_STATCMD,
						data: CMD_TERMINATE};                 // RL11
					st_d = S_STAT;
					last_d = 1'b0;
					rq_d.op = PDL_OP_INIT;
				end
			end
			S_STAT: begin
				if (!busy) begin
					tmr_d = 4'(STROBE_CYC);
					io_d.rd = 1'b1;
					io_d.addr = PORT_STATCMD;
					st_d = S_ISTAT;
				end
			end
			S_ISTAT: begin
				// Capture bytes and status at strobe end
				if (io_q.rd && tmr_q == 4'h1) begin
					if (io_q.addr == PORT_DATA) begin
						hold_d = io_rdata_i;
						st_d = S_STAT;
					end else if (io_q.addr == PORT_STATCMD) begin
						res_d.status = io_rdata_i;
					end else begin
						res_d.int_status = io_rdata_i;      // RL3 RL4 RL5 RL27
						st_d = S_DONE;
						// Decide from status whether the frame goes on
						if ((res_q.status & ~(8'h01 << ST_SERVICE_REQUEST_FLAG)) != 8'h00) begin
							res_d.error = res_q.status[ST_RNS] || res_q.status[ST_TNS]
								|| res_q.status[ST_FCS] || res_q.status[ST_ABORT]; // RL15
						end else if (rq_q.op == PDL_OP_TXCPU || rq_q.op == PDL_OP_RXCPU)
						begin
							st_d = S_WAIT;
						end
						// Byte read with EOF status is dropped
						if (rq_q.op == PDL_OP_RXCPU && !res_q.status[ST_EOF]
							&& (res_q.status & ~(8'h01 << ST_SERVICE_REQUEST_FLAG)) == 8'h00) begin
							have_d = 1'b1;                  // RL16
						end
					end
				end else if (!busy && io_q.addr == PORT_STATCMD) begin
					// Interrupt status next, after a one-cycle gap
					tmr_d = 4'(STROBE_CYC);
					io_d = '{rd: 1'b1, wr: 1'b0, addr: PORT_INTSTAT, data: 8'h00};
				end
			end
			S_DONE: begin
				if (!busy) begin
					done_d = 1'b1;
					st_d = S_IDLE;
				end
			end
			default: begin
				st_d = S_IDLE;
			end
		endcase
		// Data read enters the state that collects status
		if (st_q == S_DATA && st_d == S_STAT && rq_q.op == PDL_OP_RXCPU) begin
			st_d = S_ISTAT;
		end
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= S_IDLE;
			rq_q <= '0;
			io_q <= '0;
			step_q <= '0;
			tmr_q <= '0;
			last_q <= 1'b0;
			done_q <= 1'b0;
			res_q <= '0;
			hold_q <= '0;
			have_q <= 1'b0;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			req_ready_o <= 1'b0;
			tx_ready_o <= 1'b0;
			rx_data_o <= '0;
			rx_valid_o <= 1'b0;
		end else if (ce_i) begin
			st_q <= st_d;
			rq_q <= rq_d;
			io_q <= io_d;
			step_q <= step_d;
			tmr_q <= tmr_d;
			last_q <= last_d;
			done_q <= done_d;
			res_q <= res_d;
			hold_q <= hold_d;
			have_q <= have_d;
			rd_n_q <= !io_d.rd;
			wr_n_q <= !io_d.wr;
			req_ready_o <= (st_d == S_IDLE);
			tx_ready_o <= (st_q == S_DATA) && (st_d == S_STAT) && !io_q.wr
				&& rq_q.op == PDL_OP_TXCPU && !busy;
			rx_data_o <= f_pop ? f_out : rx_data_o;
			rx_valid_o <= f_pop || (rx_valid_o && !rx_ready_i);
		end
	end

	// Bus pins straight from the cycle register and the strobe registers
	assign io_addr_o    = io_q.addr;
	assign io_wdata_o   = io_q.data;
	assign io_data_oe_o = io_q.wr;
	assign io_rd_n_o    = rd_n_q;
	assign io_wr_n_o    = wr_n_q;
	assign done_o       = done_q;
	assign res_o        = res_q;
endmodule : pdl_host

// ---- include/pdl_pkg.sv ----
package pdl_pkg;

	// ****************************************
	// Port map of the adapter (I/O addresses)
	// ****************************************
	localparam logic [9:0] PORT_DATA     = 10'h380;
	localparam logic [9:0] PORT_STATCMD  = 10'h381;
	localparam logic [9:0] PORT_GROUP    = 10'h382;
	localparam logic [9:0] PORT_TXADDR   = 10'h383;
	localparam logic [9:0] PORT_TXCOUNT  = 10'h384;
	localparam logic [9:0] PORT_RXADDR   = 10'h385;
	localparam logic [9:0] PORT_RXCOUNT  = 10'h386;
	localparam logic [9:0] PORT_STATION  = 10'h388;
	localparam logic [9:0] PORT_INTSTAT  = 10'h389;

	// ****************************************
	// Command register fields
	// ****************************************
	localparam int CMD_TXFRAME  = 7;
	localparam int CMD_TXFLAGS  = 6;
	localparam int CMD_RXHI     = 5;
	localparam int CMD_RXLO     = 4;
	localparam int CMD_CPUMODE  = 3;
	localparam int CMD_SWRESET  = 1;
	localparam logic [7:0] CMD_TERMINATE = 8'h08;
	localparam logic [7:0] CMD_RESET     = 8'h02;

	// ****************************************
	// Status register fields
	// ****************************************
	localparam int ST_EOF     = 7;
	localparam int ST_RNS     = 6;
	localparam int ST_TNS     = 5;
	localparam int ST_FCS     = 4;
	localparam int ST_ABORT   = 3;
	localparam int ST_DMATERM = 1;
	localparam int ST_SERVICE_REQUEST_FLAG   = 0;

	// ****************************************
	// Interrupt status, address and DMA counter values
	// ****************************************
	localparam int IS_LINK    = 0;
	localparam int IS_TIMER   = 1;
	localparam int IS_JUMPER  = 2;
	localparam logic [7:0] STATION_PRIMARY = 8'h01;
	localparam logic [7:0] STATION_LOW     = 8'h03;
	localparam logic [7:0] GROUP_LOW       = 8'h0F;
	localparam logic [7:0] DMA_COUNT_INIT  = 8'hFF;

	// ****************************************
	// Bus timing and receive buffer size
	// ****************************************
	localparam int STROBE_NS     = 200;
	localparam int CLK_NS        = 20;
	localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int FIFO_W        = 8;
	localparam int FIFO_D        = 8;

	// User commands
	typedef enum logic [2:0] {
		PDL_OP_INIT   = 3'b000,
		PDL_OP_TXCPU  = 3'b001,
		PDL_OP_RXCPU  = 3'b010,
		PDL_OP_TXDMA  = 3'b011,
		PDL_OP_RXDMA  = 3'b100
	} pdl_op_e;

	typedef struct packed {
		pdl_op_e    op;
		logic       flags;
		logic [1:0] rx_mode;
		logic [4:0] terminal;
		logic [3:0] group;
		logic [7:0] dma_addr;
	} pdl_req_s;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] int_status;
		logic       error;
	} pdl_res_s;

	// One I/O bus cycle
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [9:0] addr;
		logic [7:0] data;
	} pdl_io_s;

endpackage : pdl_pkg

// ---- verilog/pdl_fifo.sv ----
module pdl_fifo
	import pdl_pkg::*;
#(
	parameter int W = FIFO_W,
	parameter int D = FIFO_D
) (
	input  wire logic         clk_i,      // Clock
	input  wire logic         nrst_i,     // Async reset
	input  wire logic         en_i,       // Clock enable
	input  wire logic         clr_i,      // Flush
	input  wire logic [W-1:0] in_data_i,  // Write data
	input  wire logic         in_valid_i, // Write valid
	output logic              in_ready_o, // Not full
	output logic [W-1:0]      out_data_o, // Read data
	output logic              out_valid_o,// Not empty
	input  wire logic         out_ready_i // Read accept
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem_q [D];
	logic [W-1:0] mem_d [D];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0]   cnt_q, cnt_d;
	logic          push, pop;

	// ****************************************
	// Pointer and storage update
	// ****************************************
	always_comb begin
		push = in_valid_i && (cnt_q != (AW+1)'(D));
		pop  = out_ready_i && (cnt_q != '0);
		wp_d = wp_q;
		rp_d = rp_q;
		cnt_d = cnt_q;
		for (int i = 0; i < D; i++) begin
			mem_d[i] = mem_q[i];
		end
		if (clr_i) begin
			wp_d = '0;
			rp_d = '0;
			cnt_d = '0;
		end else begin
			if (push) begin
				mem_d[wp_q] = in_data_i;
				wp_d = AW'(wp_q + 1'b1);
			end
			if (pop) begin
				rp_d = AW'(rp_q + 1'b1);
			end
			cnt_d = (AW+1)'(cnt_q + push - pop);
		end
	end

	// Registers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else if (en_i) begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage per entry
	for (genvar g = 0; g < D; g++) begin : g_mem
		always_ff @(posedge clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				mem_q[g] <= '0;
			end else if (en_i) begin
				mem_q[g] <= mem_d[g];
			end
		end
	end

	assign in_ready_o  = (cnt_q != (AW+1)'(D));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem_q[rp_q];
endmodule : pdl_fifo

// ---- verilog/pdl_sync.sv ----
module pdl_sync
	import pdl_pkg::*;
#(
	parameter int W = 4
) (
	input  wire logic         clk_i,   // Clock
	input  wire logic         nrst_i,  // Async reset
	input  wire logic         en_i,    // Clock enable
	input  wire logic [W-1:0] async_i, // Pin levels
	output logic [W-1:0]      sync_o   // Synchronised levels
);
	logic [W-1:0] s1_q, s2_q;

	// Two-stage synchroniser
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_q <= '0;
			s2_q <= '0;
		end else if (en_i) begin
			s1_q <= async_i;
			s2_q <= s1_q;
		end
	end

	assign sync_o = s2_q;
endmodule : pdl_sync

// ---- dv/pdl_host_checker.sv ----
module pdl_host_checker
	import pdl_pkg::*;
(
	input  wire logic       clk_i,        // Clock
	input  wire logic       nrst_i,       // Reset, low
	input  wire logic       req_valid_i,  // Request offered
	input  wire logic       req_ready_o,  // Idle
	input  wire logic       done_o,       // Done pulse
	input  wire logic [9:0] io_addr_o,    // Bus address
	input  wire logic [7:0] io_wdata_o,   // Bus write data
	input  wire logic       io_data_oe_o, // Bus drive
	input  wire logic       io_rd_n_o,    // Read strobe
	input  wire logic       io_wr_n_o     // Write strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	logic       idle_n;
	logic [4:0] low_q;
	logic [4:0] low_d;
	logic       wr_at;
	// ****
	// Strobe length counter
	// ****
	assign idle_n = io_rd_n_o & io_wr_n_o;
	assign wr_at = !io_wr_n_o;
	always_comb low_d = idle_n ? 5'h00 : low_q + 5'h01;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			low_q <= 5'h00;
		end else begin
			low_q <= low_d;
		end
	end
	// ****
	// Bus and handshake properties
	// ****
	property p_one_strobe;
		!(!io_rd_n_o && !io_wr_n_o);
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
	property p_strobe_len;
		$rose(idle_n) |-> low_q == STROBE_CYC;
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
	property p_bus_hold;
		!idle_n && !$past(idle_n) |-> $stable(io_addr_o) && $stable(io_wdata_o);
	endproperty
	a_bus_hold: assert property (p_bus_hold) else $error("bus moved in strobe");
	property p_oe;
		(wr_at |-> io_data_oe_o) and (!io_rd_n_o |-> !io_data_oe_o);
	endproperty
	a_oe: assert property (p_oe) else $error("drive enable wrong");
	property p_done;
		done_o |=> !done_o;
	endproperty
	a_done: assert property (p_done) else $error("done too long");
	property p_take;
		req_valid_i && req_ready_o |=> !req_ready_o;
	endproperty
	a_take: assert property (p_take) else $error("ready after take");
	property p_station;
		wr_at && io_addr_o == PORT_STATION |-> io_wdata_o == STATION_PRIMARY
			|| (io_wdata_o[2:0] == 3'h3 && io_wdata_o[7:3] != 5'h00);
	endproperty
	a_station: assert property (p_station) else $error("bad station");
	property p_count;
		wr_at && (io_addr_o == PORT_TXCOUNT || io_addr_o == PORT_RXCOUNT)
			|-> io_wdata_o == DMA_COUNT_INIT;
	endproperty
	a_count: assert property (p_count) else $error("bad counter");
	property p_group;
		wr_at && io_addr_o == PORT_GROUP |-> io_wdata_o[3:0] == 4'hF;
	endproperty
	a_group: assert property (p_group) else $error("bad group");
endmodule : pdl_host_checker

// ---- dv/pdl_dev_model.sv ----
module pdl_dev_model
	import pdl_pkg::*;
#(
	parameter int   DEADLINE = 6250, // Six bit times in clocks
	parameter logic JUMPER   = 1'b1  // Channel jumper
) (
	input  wire logic       clk_i,   // Clock
	input  wire logic [9:0] addr_i,  // I/O address
	input  wire logic [7:0] wdata_i, // Host data
	input  wire logic       rd_n_i,  // Read strobe
	input  wire logic       wr_n_i,  // Write strobe
	input  wire logic [3:0] nrx_i,   // Bytes per frame
	input  wire logic       fcs_i,   // Bad check sequence
	output logic [7:0]      rdata_o, // Data to host
	output logic            irq_o    // Interrupt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] station_q = 8'h00, group_q = 8'h00, txaddr_q = 8'h00, rxaddr_q = 8'h00;
	logic [7:0] cmd_q = 8'h00, txcmd_q = 8'h00, rxcmd_q = 8'h00, st_q = 8'h00;
	logic [7:0] ev_st = 8'h00, last_q = 8'h00, d_q = 8'h00;
	logic [9:0] a_q = 10'h000;
	logic       isr_q = 1'b0, rd_q = 1'b0, wr_q = 1'b0, swap;
	int         ev = 0, tmo = 0, idx = 0;
	logic [7:0] txq[$];
	initial irq_o = 1'b0;
	assign swap = (station_q != STATION_PRIMARY);
	// Read data; an idle bus shows the inverse of the last value
	always_comb begin
		case (addr_i)
			PORT_DATA:    rdata_o = 8'hA0 + 8'(idx);
			PORT_STATCMD: rdata_o = st_q;
			PORT_INTSTAT: rdata_o = {5'h00, JUMPER, 1'b0, isr_q};
			default:      rdata_o = 8'hFF;
		endcase
		if (rd_n_i) rdata_o = ~last_q;
	end
	// Events, deadlines and strobe side effects
	always @(posedge clk_i) begin
		rd_q <= !rd_n_i;
		wr_q <= !wr_n_i;
		if (!rd_n_i || !wr_n_i) a_q <= addr_i;
		if (!wr_n_i) d_q <= wdata_i;
		if (!rd_n_i) last_q <= rdata_o;
		if (!wr_n_i) last_q <= wdata_i;
		if (ev > 0) ev <= ev - 1;
		if (ev == 1) begin
			st_q <= st_q | ev_st;
			irq_o <= 1'b1;
			isr_q <= 1'b1;
			if (ev_st[ST_EOF]) cmd_q[5:4] <= 2'h0;
		end
		tmo <= st_q[ST_SERVICE_REQUEST_FLAG] ? tmo + 1 : 0;
		if (tmo == DEADLINE) begin
			st_q[cmd_q[CMD_TXFRAME] ? ST_TNS : ST_RNS] <= 1'b1;
			irq_o <= 1'b1;
		end
		if (rd_q && rd_n_i) begin
			irq_o <= 1'b0;
			case (a_q)
				PORT_STATCMD: st_q <= st_q & 8'h01;
				PORT_INTSTAT: isr_q <= 1'b0;
				PORT_DATA: begin
					st_q[ST_SERVICE_REQUEST_FLAG] <= 1'b0;
					idx <= idx + 1;
					if (idx < nrx_i) ev <= 40;
					ev_st <= (idx + 1 < nrx_i) ? 8'h01 : {1'b1, 2'h0, fcs_i, 4'h1};
				end
				default: ;
			endcase
		end
		if (wr_q && wr_n_i) begin
			case (a_q)
				PORT_STATION: station_q <= d_q;
				PORT_GROUP:   group_q <= d_q;
				PORT_TXADDR:  txaddr_q <= d_q;
				PORT_RXADDR:  rxaddr_q <= d_q;
				PORT_DATA: begin
					txq.push_back(d_q);
					st_q[ST_SERVICE_REQUEST_FLAG] <= 1'b0;
					irq_o <= 1'b0;
					ev <= 40;
					ev_st <= 8'h01;
				end
				PORT_STATCMD: begin
					cmd_q <= d_q;
					irq_o <= 1'b0;
					ev <= 30;
					idx <= 0;
					if (d_q[CMD_SWRESET]) begin
						station_q <= STATION_PRIMARY;
						st_q <= 8'h00;
						ev <= 0;
					end else if (d_q == CMD_TERMINATE) begin
						ev_st <= 8'h00;
					end else if (d_q[CMD_TXFRAME]) begin
						txcmd_q <= d_q;
						ev_st <= d_q[CMD_CPUMODE] ? 8'h01 : 8'h02;
					end else begin
						rxcmd_q <= d_q;
						ev_st <= d_q[CMD_CPUMODE] ? 8'h01 : 8'h82;
					end
				end
				default: ;
			endcase
		end
	end
endmodule : pdl_dev_model

// ---- dv/pdl_host_tb.sv ----
module pdl_host_tb
	import pdl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk_i = 1'b0, nrst_i = 1'b0, req_valid = 1'b0, tx_valid = 1'b0;
	logic       tx_last = 1'b0, rx_ready = 1'b0, stall = 1'b0, fcs = 1'b0;
	logic [7:0] tx_data = 8'h00, rx_data, io_wdata, io_rdata;
	logic [3:0] nrx = 4'h2;
	pdl_req_s   req = '0;
	pdl_res_s   res;
	logic       req_ready, tx_ready, rx_valid, done, io_oe, rd_n, wr_n, irq;
	logic [9:0] io_addr;
	int         failures = 0, total_checks = 0, i;
	logic [7:0] rxq[$];
	initial forever #10 clk_i = ~clk_i;
	pdl_host uut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .req_valid_i(req_valid),
		.req_i(req), .req_ready_o(req_ready), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
		.tx_last_i(tx_last), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
		.rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .done_o(done), .res_o(res),
		.io_addr_o(io_addr), .io_wdata_o(io_wdata), .io_data_oe_o(io_oe),
		.io_rdata_i(io_rdata), .io_rd_n_o(rd_n), .io_wr_n_o(wr_n), .irq_i(irq));
	pdl_dev_model dev (.clk_i(clk_i), .addr_i(io_addr), .wdata_i(io_wdata), .rd_n_i(rd_n),
		.wr_n_i(wr_n), .nrx_i(nrx), .fcs_i(fcs), .rdata_o(io_rdata), .irq_o(irq));
	// Byte source for transmit, sink for receive
	always @(posedge clk_i) begin
		rx_ready <= !stall;
		if (rx_valid && rx_ready) rxq.push_back(rx_data);
		if (tx_valid && tx_ready) begin
			tx_data <= tx_data + 8'h01;
			tx_last <= (tx_data == 8'h31);
			tx_valid <= (tx_data != 8'h32);
		end
	end
	task automatic summarize();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One user operation, waited for under a bound
	task automatic run(input pdl_op_e op, input logic fl, input logic [1:0] m,
		input logic [4:0] t, input logic [3:0] g, input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk_i);
		while (req_ready !== 1'b1 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		chk("ready", 8'h01, {7'h00, req_ready});
		if (req_ready !== 1'b1) summarize();
		req <= '{op, fl, m, t, g, a};
		req_valid <= 1'b1;
		@(posedge clk_i);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (done !== 1'b1 && n < 20000);
		chk("done", 8'h01, {7'h00, done});
		if (done !== 1'b1) summarize();
	endtask : run
	task automatic drain(input int cnt);
		int n;
		for (n = 0; n < 50 && rx_valid !== 1'b0; n++) @(negedge clk_i);
		chk("rx idle", 8'h00, {7'h00, rx_valid});
		if (rx_valid !== 1'b0) summarize();
		chk("rx count", 8'(cnt), 8'(rxq.size()));
		for (n = 0; n < cnt; n++) chk("rx byte", 8'hA0 + 8'(n), rxq[n]);
		rxq.delete();
	endtask : drain
	initial begin
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		// Station set-up, primary then secondary
		run(PDL_OP_INIT, 1'b0, 2'h0, 5'h00, 4'h0, 8'h00);
		chk("station", STATION_PRIMARY, dev.station_q);
		chk("swap", 8'h00, {7'h00, dev.swap});
		run(PDL_OP_INIT, 1'b0, 2'h0, 5'h05, 4'h0, 8'h00);
		chk("station", 8'h2B, dev.station_q);
		chk("swap", 8'h01, {7'h00, dev.swap});
		// CPU transmit of three bytes
		@(posedge clk_i);
		tx_data <= 8'h30;
		tx_valid <= 1'b1;
		run(PDL_OP_TXCPU, 1'b0, 2'h0, 5'h00, 4'h0, 8'h00);
		chk("tx count", 8'h03, 8'(dev.txq.size()));
		for (i = 0; i < 3; i++) chk("tx byte", 8'h30 + 8'(i), dev.txq[i]);
		chk("tx cmd", 8'h88, dev.txcmd_q);
		chk("last cmd", CMD_TERMINATE, dev.cmd_q);
		chk("error", 8'h00, {7'h00, res.error});
		chk("int status", 8'h05, res.int_status);
		// CPU receive in each address mode
		for (i = 1; i < 4; i++) begin
			run(PDL_OP_RXCPU, 1'b0, 2'(i), 5'h00, 4'h3, 8'h00);
			chk("rx cmd", {2'h0, 2'(i), 4'h8}, dev.rxcmd_q);
			chk("mode end", 8'h00, {6'h00, dev.cmd_q[5:4]});
			chk("group", 8'h3F, dev.group_q);
			chk("status", 8'h80, res.status);
			drain(2);
		end
		// Eight-byte frame held by a stalled sink, then drained
		@(posedge clk_i);
		nrx <= 4'h8;
		stall <= 1'b1;
		run(PDL_OP_RXCPU, 1'b0, 2'h1, 5'h00, 4'h0, 8'h00);
		chk("held", 8'h00, 8'(rxq.size()));
		chk("rx valid", 8'h01, {7'h00, rx_valid});
		@(posedge clk_i);
		stall <= 1'b0;
		drain(8);
		chk("rx valid", 8'h00, {7'h00, rx_valid});
		// Frame with a check sequence error
		@(posedge clk_i);
		nrx <= 4'h1;
		fcs <= 1'b1;
		run(PDL_OP_RXCPU, 1'b0, 2'h1, 5'h00, 4'h0, 8'h00);
		chk("error", 8'h01, {7'h00, res.error});
		chk("status", 8'h90, res.status);
		drain(1);
		fcs <= 1'b0;
		// DMA transmit with both interframe fills
		for (i = 0; i < 2; i++) begin
			run(PDL_OP_TXDMA, 1'(i), 2'h0, 5'h00, 4'h0, 8'h5A);
			chk("tx cmd", {1'b1, 1'(i), 6'h00}, dev.txcmd_q);
			chk("tx addr", 8'h5A, dev.txaddr_q);
			chk("status", 8'h02, res.status);
			chk("error", 8'h00, {7'h00, res.error});
		end
		// DMA receive, group mode
		run(PDL_OP_RXDMA, 1'b0, 2'h2, 5'h00, 4'hA, 8'hC3);
		chk("rx addr", 8'hC3, dev.rxaddr_q);
		chk("group", 8'hAF, dev.group_q);
		chk("rx cmd", 8'h20, dev.rxcmd_q);
		chk("status", 8'h82, res.status);
		summarize();
	end
endmodule : pdl_host_tb
bind pdl_host pdl_host_checker u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
	.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .done_o(done_o),
	.io_addr_o(io_addr_o), .io_wdata_o(io_wdata_o), .io_data_oe_o(io_data_oe_o),
	.io_rd_n_o(io_rd_n_o), .io_wr_n_o(io_wr_n_o));
